// ==== hdl/ldsc_regs.vh ====
`ifndef LDSC_REGS_VH
`define LDSC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LDSC_ADDR_DATA_FMT     8'h08
`define LDSC_ADDR_TRIG_UPPER   8'h0B
`define LDSC_ADDR_SAMP_CTRL    8'h0C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LDSC_RST_DATA_FMT      8'h00
`define LDSC_RST_TRIG_UPPER    8'h00
`define LDSC_RST_SAMP_CTRL     8'h00

// ----------------------------------------
// Data format control fields
// ----------------------------------------
`define LDSC_DF_RAIL_HI        7
`define LDSC_DF_RAIL_LO        6
`define LDSC_DF_EXT_RTZ        4
`define LDSC_DF_LAS_DIS        3
`define LDSC_DF_MODE_HI        1
`define LDSC_DF_MODE_LO        0
`define LDSC_DF_WMASK          8'hDB

// ----------------------------------------
// Sampler control fields
// ----------------------------------------
`define LDSC_SC_EN             7
`define LDSC_SC_CONT           6
`define LDSC_SC_GAIN_HI        5
`define LDSC_SC_GAIN_LO        4
`define LDSC_SC_TGT_HI         3
`define LDSC_SC_TGT_LO         2
`define LDSC_SC_TRIG_HI        1
`define LDSC_SC_TRIG_LO        0

// ----------------------------------------
// Encodings
// ----------------------------------------
`define LDSC_MODE_555          2'h0
`define LDSC_MODE_PACKED       2'h1
`define LDSC_MODE_TEN          2'h2
`define LDSC_MODE_SERIAL       2'h3
`define LDSC_RAIL_1V8          2'h0
`define LDSC_RAIL_3V3          2'h3
`define LDSC_TGT_VSENSE        2'h0
`define LDSC_TGT_CH1           2'h1
`define LDSC_TGT_CH2           2'h2
`define LDSC_TGT_CH3           2'h3

`endif

// ==== hdl/ldsc_pixel_unpack.v ====
`timescale 1ns/1ps
`include "ldsc_regs.vh"

// ----------------------------------------
// Pixel word capture per data format
// ----------------------------------------
module ldsc_pixel_unpack #(
  parameter DW = 10
) (
  input  wire          MCLK_I,
  input  wire          RESET_N_I,
  input  wire [1:0]    mode_i,
  input  wire [14:0]   rise_word_i,
  input  wire [14:0]   fall_word_i,
  input  wire          frame_sync_i,
  input  wire          ser_valid_i,
  input  wire [1:0]    ser_chan_i,
  input  wire [DW-1:0] ser_data_i,
  output reg  [DW-1:0] red_o,
  output reg  [DW-1:0] green_o,
  output reg  [DW-1:0] blue_o
);

  reg [1:0] color_reg;

  always @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      red_o     <= {DW{1'b0}};
      green_o   <= {DW{1'b0}};
      blue_o    <= {DW{1'b0}};
      color_reg <= 2'h0;
    end else begin
      case (mode_i)
        `LDSC_MODE_555: begin
          // Each edge brings half of every colour; 5 MSBs first
          red_o   <= {rise_word_i[14:10], fall_word_i[14:10]};
          green_o <= {rise_word_i[9:5], fall_word_i[9:5]};
          blue_o  <= {rise_word_i[4:0], fall_word_i[4:0]};
        end
        `LDSC_MODE_PACKED: begin
          // Green split over both packets, upper half with red
          red_o   <= rise_word_i[14:5];
          blue_o  <= fall_word_i[14:5];
          green_o <= {rise_word_i[4:0], fall_word_i[4:0]};
        end
        `LDSC_MODE_TEN: begin
          // Colour order restarts at frame sync
          if (frame_sync_i)
            color_reg <= 2'h1;
          else if (color_reg == 2'h2)
            color_reg <= 2'h0;
          else
            color_reg <= color_reg + 2'h1;
          case (frame_sync_i ? 2'h0 : color_reg)
            2'h0:    red_o   <= rise_word_i[9:0];
            2'h1:    green_o <= rise_word_i[9:0];
            default: blue_o  <= rise_word_i[9:0];
          endcase
        end
        default: begin
          // Parallel bus ignored; host supplies channel data
          if (ser_valid_i) begin
            case (ser_chan_i)
              2'h1:    red_o   <= ser_data_i;
              2'h2:    green_o <= ser_data_i;
              2'h3:    blue_o  <= ser_data_i;
              default: red_o   <= red_o;
            endcase
          end
        end
      endcase
    end
  end

endmodule // ldsc_pixel_unpack

// ==== hdl/ldsc_sampler_seq.v ====
`timescale 1ns/1ps
`include "ldsc_regs.vh"

// ----------------------------------------
// Sampler trigger and shot sequencing
// ----------------------------------------
module ldsc_sampler_seq #(
  parameter DW = 10
) (
  input  wire          MCLK_I,
  input  wire          RESET_N_I,
  input  wire          enable_i,
  input  wire          continuous_i,
  input  wire [DW-1:0] trigger_i,
  input  wire [DW-1:0] dac_word_i,
  output reg           sample_o,
  output wire          shot_done_o
);

  always @(posedge MCLK_I) begin
    if (!RESET_N_I)
      sample_o <= 1'b0;
    else
      // Shot in flight blocks a second strobe while enable clears
      sample_o <= enable_i && (dac_word_i == trigger_i) && !shot_done_o;
  end

  // Single shot ends after the first sample
  assign shot_done_o = sample_o && !continuous_i;

endmodule // ldsc_sampler_seq

// ==== hdl/ldsc_cfg_top.v ====
// Operation
// - Return-to-zero bit set selects external asynchronous source; clear is clock-synchronous.
// - Look-ahead sleep bit set disables look-ahead sleep; clear keeps it on.
// - Format 11 ignores parallel bus; per-channel pixels come over control interface.
// - Format 10 captures ten bits per rising edge, colour order aligned by frame sync.
// - Format 01 takes 15-bit RG and BG packets on both edges.
// - Format 00 takes 5/5/5 words; full pixel built over both edges.
// - Trigger point: bits 9..2 from trigger register, 1..0 from control.
// - Trigger point compared with word driving output DAC to start sampling.
// - Sampler control top bit turns sampler on; resets to zero.
// - Continuous mode samples repeatedly until software clears enable.
// - Single-shot mode takes one sample then hardware clears enable.
// - Gain field: 11 full, 10 three quarters, 01 half, 00 quarter.
// - Target field: 11 ch3, 10 ch2, 01 ch1, 00 voltage sense node.
`timescale 1ns/1ps
`include "ldsc_regs.vh"

module ldsc_cfg_top #(
  parameter DW = 10
) (
  input  wire          MCLK_I,
  input  wire          RESET_N_I,
  input  wire [7:0]    REG_ADDR_I,
  input  wire [7:0]    REG_WDATA_I,
  input  wire          REG_WR_I,
  input  wire          REG_RD_I,
  output reg  [7:0]    REG_RDATA_O,
  input  wire [14:0]   PIX_RISE_I,
  input  wire [14:0]   PIX_FALL_I,
  input  wire          FRAME_SYNC_I,
  input  wire          SER_PIX_VALID_I,
  input  wire [1:0]    SER_PIX_CHAN_I,
  input  wire [DW-1:0] SER_PIX_DATA_I,
  input  wire [DW-1:0] DAC_WORD_I,
  input  wire          RETURN_TO_ZERO_PULSE_I,
  input  wire          RTZ_SYNC_PULSE_I,
  output wire [1:0]    IO_SUPPLY_LEVEL_O,
  output wire          EXTERNAL_ZERO_RETURN_SELECT_O,
  output reg           ZERO_RETURN_O,
  output wire          LOOKAHEAD_SLEEP_EN_O,
  output wire [1:0]    DATA_MODE_O,
  output wire [DW-1:0] RED_O,
  output wire [DW-1:0] GREEN_O,
  output wire [DW-1:0] BLUE_O,
  output wire          SAMPLER_ON_O,
  output wire          SAMPLE_STROBE_O,
  output wire [DW-1:0] TRIGGER_POINT_O,
  output reg  [1:0]    GAIN_QUARTERS_M1_O,
  output reg  [1:0]    TARGET_SEL_O,
  output reg           LASER_VOLTAGE_SENSE_NODE_O,
  output reg           OUTPUT_CHANNEL_ONE_O,
  output reg           OUTPUT_CHANNEL_TWO_O,
  output reg           OUTPUT_CHANNEL_THREE_O
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg  [7:0] data_fmt_reg;
  reg  [7:0] data_fmt_next;
  reg  [7:0] trig_upper_reg;
  reg  [7:0] samp_ctrl_reg;
  reg  [7:0] samp_ctrl_next;
  wire       shot_done;
  wire       sample_pulse;

  wire wr_fmt  = REG_WR_I && (REG_ADDR_I == `LDSC_ADDR_DATA_FMT);
  wire wr_trig = REG_WR_I && (REG_ADDR_I == `LDSC_ADDR_TRIG_UPPER);
  wire wr_ctrl = REG_WR_I && (REG_ADDR_I == `LDSC_ADDR_SAMP_CTRL);

  // Rail field held as written; invalid codes are host's duty
  always @* begin
    data_fmt_next = data_fmt_reg;
    if (wr_fmt)
      data_fmt_next = REG_WDATA_I & `LDSC_DF_WMASK;
  end

  // Hardware clear of enable loses to a host write in the same cycle
  always @* begin
    samp_ctrl_next = samp_ctrl_reg;
    if (shot_done)
      samp_ctrl_next[`LDSC_SC_EN] = 1'b0;
    if (wr_ctrl)
      samp_ctrl_next = REG_WDATA_I;
  end

  always @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      data_fmt_reg   <= `LDSC_RST_DATA_FMT;
      trig_upper_reg <= `LDSC_RST_TRIG_UPPER;
      samp_ctrl_reg  <= `LDSC_RST_SAMP_CTRL;
    end else begin
      data_fmt_reg  <= data_fmt_next;
      samp_ctrl_reg <= samp_ctrl_next;
      if (wr_trig)
        trig_upper_reg <= REG_WDATA_I;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Registered read; a read leaves register contents unchanged
  always @(posedge MCLK_I) begin
    if (!RESET_N_I)
      REG_RDATA_O <= 8'h00;
    else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `LDSC_ADDR_DATA_FMT:   REG_RDATA_O <= data_fmt_reg;
        `LDSC_ADDR_TRIG_UPPER: REG_RDATA_O <= trig_upper_reg;
        `LDSC_ADDR_SAMP_CTRL:  REG_RDATA_O <= samp_ctrl_reg;
        default:               REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Data control outputs
  // ----------------------------------------
  assign IO_SUPPLY_LEVEL_O =
    data_fmt_reg[`LDSC_DF_RAIL_HI:`LDSC_DF_RAIL_LO];
  assign EXTERNAL_ZERO_RETURN_SELECT_O = data_fmt_reg[`LDSC_DF_EXT_RTZ];
  assign LOOKAHEAD_SLEEP_EN_O = !data_fmt_reg[`LDSC_DF_LAS_DIS];
  assign DATA_MODE_O = data_fmt_reg[`LDSC_DF_MODE_HI:`LDSC_DF_MODE_LO];

  // External and internal pulses are both registered on MCLK_I
  always @(posedge MCLK_I) begin
    if (!RESET_N_I)
      ZERO_RETURN_O <= 1'b0;
    else if (data_fmt_reg[`LDSC_DF_EXT_RTZ])
      ZERO_RETURN_O <= RETURN_TO_ZERO_PULSE_I;
    else
      ZERO_RETURN_O <= RTZ_SYNC_PULSE_I;
  end

  ldsc_pixel_unpack #(
    .DW (DW)
  ) u_unpack (
    .MCLK_I       (MCLK_I),
    .RESET_N_I    (RESET_N_I),
    .mode_i       (DATA_MODE_O),
    .rise_word_i  (PIX_RISE_I),
    .fall_word_i  (PIX_FALL_I),
    .frame_sync_i (FRAME_SYNC_I),
    .ser_valid_i  (SER_PIX_VALID_I),
    .ser_chan_i   (SER_PIX_CHAN_I),
    .ser_data_i   (SER_PIX_DATA_I),
    .red_o        (RED_O),
    .green_o      (GREEN_O),
    .blue_o       (BLUE_O)
  );

  // ----------------------------------------
  // Sampler
  // ----------------------------------------
  assign TRIGGER_POINT_O = {trig_upper_reg,
    samp_ctrl_reg[`LDSC_SC_TRIG_HI:`LDSC_SC_TRIG_LO]};
  assign SAMPLER_ON_O    = samp_ctrl_reg[`LDSC_SC_EN];
  assign SAMPLE_STROBE_O = sample_pulse;

  ldsc_sampler_seq #(
    .DW (DW)
  ) u_seq (
    .MCLK_I       (MCLK_I),
    .RESET_N_I    (RESET_N_I),
    .enable_i     (samp_ctrl_reg[`LDSC_SC_EN]),
    .continuous_i (samp_ctrl_reg[`LDSC_SC_CONT]),
    .trigger_i    (TRIGGER_POINT_O),
    .dac_word_i   (DAC_WORD_I),
    .sample_o     (sample_pulse),
    .shot_done_o  (shot_done)
  );

  // Target decode shared by the four one-hot select outputs
  function tgt_hit;
    input [1:0] sel;
    input [1:0] code;
    begin
      tgt_hit = (sel == code);
    end
  endfunction

  wire [1:0] tgt_field = samp_ctrl_reg[`LDSC_SC_TGT_HI:`LDSC_SC_TGT_LO];

  // Gain output is quarters minus one: 0=1/4 .. 3=1
  always @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      GAIN_QUARTERS_M1_O         <= 2'h0;
      TARGET_SEL_O               <= `LDSC_TGT_VSENSE;
      LASER_VOLTAGE_SENSE_NODE_O <= 1'b1;
      OUTPUT_CHANNEL_ONE_O       <= 1'b0;
      OUTPUT_CHANNEL_TWO_O       <= 1'b0;
      OUTPUT_CHANNEL_THREE_O     <= 1'b0;
    end else begin
      GAIN_QUARTERS_M1_O <=
        samp_ctrl_reg[`LDSC_SC_GAIN_HI:`LDSC_SC_GAIN_LO];
      TARGET_SEL_O               <= tgt_field;
      LASER_VOLTAGE_SENSE_NODE_O <= tgt_hit(tgt_field, `LDSC_TGT_VSENSE);
      OUTPUT_CHANNEL_ONE_O       <= tgt_hit(tgt_field, `LDSC_TGT_CH1);
      OUTPUT_CHANNEL_TWO_O       <= tgt_hit(tgt_field, `LDSC_TGT_CH2);
      OUTPUT_CHANNEL_THREE_O     <= tgt_hit(tgt_field, `LDSC_TGT_CH3);
    end
  end

endmodule // ldsc_cfg_top

// ==== testbench/ldsc_cfg_checker.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module ldsc_cfg_checker #(
  parameter DW = 10
) (
  input wire          MCLK_I,
  input wire          RESET_N_I,
  input wire [7:0]    REG_ADDR_I,
  input wire [7:0]    REG_WDATA_I,
  input wire          REG_WR_I,
  input wire          REG_RD_I,
  input wire [7:0]    REG_RDATA_O,
  input wire [DW-1:0] DAC_WORD_I,
  input wire          RETURN_TO_ZERO_PULSE_I,
  input wire          RTZ_SYNC_PULSE_I,
  input wire          EXTERNAL_ZERO_RETURN_SELECT_O,
  input wire          ZERO_RETURN_O,
  input wire          LOOKAHEAD_SLEEP_EN_O,
  input wire          SAMPLER_ON_O,
  input wire          SAMPLE_STROBE_O,
  input wire [DW-1:0] TRIGGER_POINT_O
);
  wire wr_fmt   = REG_WR_I && REG_ADDR_I == 8'h08;
  wire wr_trg   = REG_WR_I && REG_ADDR_I == 8'h0B;
  wire wr_ctl   = REG_WR_I && REG_ADDR_I == 8'h0C;
  wire rtz_pick = EXTERNAL_ZERO_RETURN_SELECT_O ? RETURN_TO_ZERO_PULSE_I : RTZ_SYNC_PULSE_I;
  reg  cont_reg;
  // Mode bit is not visible at the ports, so mirror it
  always @(posedge MCLK_I) begin
    if (!RESET_N_I) cont_reg <= 1'b0;
    else if (wr_ctl) cont_reg <= REG_WDATA_I[6];
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_hit;
    SAMPLER_ON_O && DAC_WORD_I == TRIGGER_POINT_O && !REG_WR_I && (cont_reg || !SAMPLE_STROBE_O);
  endsequence
  sequence s_shot;
    SAMPLE_STROBE_O && !REG_WR_I;
  endsequence
  chk_trig_upper:
    assert property (wr_trg |=> TRIGGER_POINT_O[DW-1:2] == $past(REG_WDATA_I)) else $error("trig");
  chk_sampler_on:
    assert property (wr_ctl |=> SAMPLER_ON_O == $past(REG_WDATA_I[7])) else $error("enable");
  chk_sleep_inv:
    assert property (wr_fmt |=> LOOKAHEAD_SLEEP_EN_O == !$past(REG_WDATA_I[3])) else $error("sleep");
  chk_rtz_source:
    assert property (1'b1 |=> ZERO_RETURN_O == $past(rtz_pick)) else $error("rtz source");
  chk_hit_strobe:
    assert property (s_hit |=> SAMPLE_STROBE_O) else $error("no strobe on match");
  chk_single_clr:
    assert property (s_shot ##0 !cont_reg |=> !SAMPLER_ON_O) else $error("single shot");
  chk_cont_keep:
    assert property (s_shot ##0 (cont_reg && SAMPLER_ON_O) |=> SAMPLER_ON_O)
      else $error("continuous");
  chk_shot_once:
    assert property (s_shot ##0 !cont_reg |=> !SAMPLE_STROBE_O) else $error("second shot");
  chk_rsvd_zero:
    assert property (REG_RD_I && REG_ADDR_I == 8'h08 |=> REG_RDATA_O[5] == 1'b0
      && REG_RDATA_O[2] == 1'b0) else $error("reserved bits");
endmodule // ldsc_cfg_checker

bind ldsc_cfg_top ldsc_cfg_checker #(.DW(DW)) u_chk (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .DAC_WORD_I(DAC_WORD_I),
  .RETURN_TO_ZERO_PULSE_I(RETURN_TO_ZERO_PULSE_I), .RTZ_SYNC_PULSE_I(RTZ_SYNC_PULSE_I),
  .EXTERNAL_ZERO_RETURN_SELECT_O(EXTERNAL_ZERO_RETURN_SELECT_O),
  .ZERO_RETURN_O(ZERO_RETURN_O), .LOOKAHEAD_SLEEP_EN_O(LOOKAHEAD_SLEEP_EN_O),
  .SAMPLER_ON_O(SAMPLER_ON_O), .SAMPLE_STROBE_O(SAMPLE_STROBE_O),
  .TRIGGER_POINT_O(TRIGGER_POINT_O)
);

// ==== testbench/test_laser_driver_data_sampler_cfg.sv ====
`timescale 1ns/1ps
module test_laser_driver_data_sampler_cfg;
  reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sync = 1'b0, sv = 1'b0;
  reg         rz_x = 1'b0, rz_s = 1'b0, cyc_on = 1'b0;
  reg  [7:0]  addr = 8'h00, wdata = 8'h00, d = 8'h00, t = 8'h00;
  reg  [14:0] rise = 15'h0000, fall = 15'h0000;
  reg  [1:0]  sch = 2'h0, ph = 2'h0;
  reg  [9:0]  sdat = 10'h000, dac = 10'h000;
  reg  [29:0] cw = 30'h00000000;
  reg  [31:0] lfsr = 32'h0001539D;
  wire [7:0]  rdata;
  wire [1:0]  rail, mode, gain, tsel;
  wire        ext, zr, slp, son, stb, vs, c1, c2, c3;
  wire [9:0]  red, green, blue, tp;
  integer     n_mismatch = 0, samples_checked = 0, cyc = 0, i = 0;

  ldsc_cfg_top #(.DW(10)) i_dut (
    .MCLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .PIX_RISE_I(rise),
    .PIX_FALL_I(fall), .FRAME_SYNC_I(sync), .SER_PIX_VALID_I(sv), .SER_PIX_CHAN_I(sch),
    .SER_PIX_DATA_I(sdat), .DAC_WORD_I(dac), .RETURN_TO_ZERO_PULSE_I(rz_x),
    .RTZ_SYNC_PULSE_I(rz_s), .IO_SUPPLY_LEVEL_O(rail), .EXTERNAL_ZERO_RETURN_SELECT_O(ext),
    .ZERO_RETURN_O(zr), .LOOKAHEAD_SLEEP_EN_O(slp), .DATA_MODE_O(mode), .RED_O(red),
    .GREEN_O(green), .BLUE_O(blue), .SAMPLER_ON_O(son), .SAMPLE_STROBE_O(stb),
    .TRIGGER_POINT_O(tp), .GAIN_QUARTERS_M1_O(gain), .TARGET_SEL_O(tsel),
    .LASER_VOLTAGE_SENSE_NODE_O(vs), .OUTPUT_CHANNEL_ONE_O(c1),
    .OUTPUT_CHANNEL_TWO_O(c2), .OUTPUT_CHANNEL_THREE_O(c3)
  );

  always #20 clk = ~clk;

  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  task rreg(input [7:0] a, input [7:0] exp);
    begin
      addr = a;
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(1);
      check(rdata, exp);
    end
  endtask

  // Every write is closed by a read, as the host must do
  task wreg(input [7:0] a, input [7:0] v);
    begin
      addr = a;
      wdata = v;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(1);
    end
  endtask

  task end_of_test;
    begin
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end

  // Colour words repeat in step with the sync marker
  always @(posedge clk) if (cyc_on) begin
    #1 rise = {5'h00, cw[ph*10 +: 10]};
    sync = (ph == 2'd0);
    ph = (ph == 2'd2) ? 2'd0 : ph + 2'd1;
  end

  initial begin
    step(10);
    rst_n = 1'b1;
    step(1);
    check({rail, ext, slp, mode, son, vs, c1, c2, c3, gain, tsel}, 16'h0880);
    rreg(8'h0C, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      lfsr = nxt(lfsr);
      d = {i[2] ? 2'b11 : 2'b00, lfsr[5:2], i[1:0]};
      wreg(8'h08, d);
      check({rail, ext, slp, mode}, {d[7:6], d[4], ~d[3], d[1:0]});
      rreg(8'h08, d & 8'hDB);
      rz_x = lfsr[8];
      rz_s = ~lfsr[8];
      step(1);
      check(zr, d[4] ? rz_x : rz_s);
    end
    wreg(8'h0A, 8'hFF);
    rreg(8'h0A, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      wreg(8'h08, i[7:0]);
      lfsr = nxt(lfsr);
      rise = lfsr[14:0];
      fall = lfsr[29:15];
      step(3);
      if (i == 0) begin
        check({red, green, blue}, {rise[14:10], fall[14:10], rise[9:5], fall[9:5], rise[4:0], fall[4:0]});
      end else begin
        check({red, green, blue}, {rise[14:5], rise[4:0], fall[4:0], fall[14:5]});
      end
    end
    cw = lfsr[31:2];
    wreg(8'h08, 8'h02);
    cyc_on = 1'b1;
    step(9);
    wreg(8'h08, 8'h03);
    cyc_on = 1'b0;
    step(2);
    check({red, green, blue}, {cw[9:0], cw[19:10], cw[29:20]});
    for (i = 1; i < 4; i = i + 1) begin
      lfsr = nxt(lfsr);
      sch = i[1:0];
      sdat = lfsr[9:0];
      sv = 1'b1;
      step(1);
      sv = 1'b0;
      step(2);
      check(i == 1 ? red : (i == 2 ? green : blue), sdat);
    end
    t = lfsr[17:10];
    wreg(8'h0B, t);
    for (i = 0; i < 4; i = i + 1) begin
      wreg(8'h0C, {2'b00, i[1:0], i[1:0], 2'b01});
      check({gain, tsel, c3, c2, c1, vs}, {i[1:0], i[1:0], 4'h1 << i[1:0]});
      check(tp, {t, 2'b01});
    end
    dac = {~t, 2'b10};
    wreg(8'h0C, 8'h81);
    check({son, stb}, 2'b10);
    dac = {t, 2'b01};
    i = 0;
    while (stb !== 1'b1 && i < 20) begin
      step(1);
      i = i + 1;
    end
    check(stb, 1'b1);
    step(1);
    check({son, stb}, 2'b00);
    step(1);
    rreg(8'h0C, 8'h01);
    wreg(8'h0C, 8'hC1);
    step(6);
    check({son, stb}, 2'b11);
    wreg(8'h0C, 8'h41);
    step(2);
    check({son, stb}, 2'b00);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(1);
    rreg(8'h0B, 8'h00);
    end_of_test;
  end
endmodule // test_laser_driver_data_sampler_cfg
